// >>> rtl/mbi_bus_if.sv
// processor memory bus interface: reset fetches, indicators, address and data drivers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - reset abandons the current core request
// - after reset release, fetch from zero
// - dummy fetches increment during reset
// - dummy fetch address wraps to zero
// - translate indicator low for user/forced
// - mode lines are inverted mode bits
// - consecutive hint when address plus four
// - consecutive hint for idle then same address
// - hint issued one cycle ahead
// - address latch holds when enable low
// - address presented one cycle ahead
// - address drivers off when enable low
// - write data driven through whole cycle
// - data drivers off when enable low
// - data drivers off except writes
// - write/read line one cycle ahead
// - request line low for next access
module mbi_bus_if
  import mbi_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // core side: request for the next bus cycle
  input wire logic [1:0] core_op_in,
  input wire logic [25:0] core_jump_addr_in,
  input wire logic core_write_in,
  input wire logic core_force_user_access_indicator_n_in,
  input wire logic [1:0] core_mode_in,
  input wire logic [31:0] core_wdata_in,
  output logic core_abort_out,
  output logic [31:0] core_rdata_out,
  output logic core_fetching_out,
  // pin side controls
  input wire logic addr_latch_enable_in,
  input wire logic addr_drive_enable_in,
  input wire logic data_drive_enable_in,
  // pin side address and status
  output logic [25:0] addr_out,
  output logic [25:0] addr_oe_n_out,
  output logic write_read_out,
  output logic mem_request_n_out,
  output logic next_addr_consecutive_out,
  output logic user_access_indicator_n_out,
  output logic [1:0] mode_n_out,
  // pin side data bus
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [31:0] data_oe_n_out
);
  typedef struct packed {
    logic [1:0] rst_a;
    logic [1:0] rst_b;
    logic [1:0] ale_s;
    logic [1:0] abe_s;
    logic [1:0] dbe_s;
    logic [1:0] ale_a;
    logic [1:0] abe_a;
    logic [1:0] dbe_a;
    logic in_reset;
    logic [25:0] addr;
    logic wr;
    logic req_n;
    logic seq;
    logic user_access_indicator_n_n;
    logic [1:0] mode_n;
    logic wr_now;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic abort;
  } mbi_st_t;
  // power-up value gives the dummy-fetch counter a known start before the first reset
  mbi_st_t st_r = '0;
  mbi_st_t st_nxt;
  mbi_cyc_if cyc ();

  logic rst_pin;
  logic ale_q;
  logic abe_q;
  logic dbe_q;
  logic [1:0] op;
  assign rst_pin = st_r.rst_b[1];
  assign ale_q = st_r.ale_a[1];
  assign abe_q = st_r.abe_a[1];
  assign dbe_q = st_r.dbe_a[1];
  assign op = core_op_in;

  // next-cycle sequencer; the reset and enable pins pass four flops first, read data one, and raw reset also acts at once
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_a = {st_r.rst_a[0], rst_in};
    st_nxt.rst_b = {st_r.rst_b[0], st_r.rst_a[1]};
    st_nxt.ale_s = {st_r.ale_s[0], addr_latch_enable_in};
    st_nxt.ale_a = {st_r.ale_a[0], st_r.ale_s[1]};
    st_nxt.abe_s = {st_r.abe_s[0], addr_drive_enable_in};
    st_nxt.abe_a = {st_r.abe_a[0], st_r.abe_s[1]};
    st_nxt.dbe_s = {st_r.dbe_s[0], data_drive_enable_in};
    st_nxt.dbe_a = {st_r.dbe_a[0], st_r.dbe_s[1]};
    st_nxt.abort = 1'b0;
    st_nxt.wr_now = st_r.wr & ~st_r.req_n;
    st_nxt.wdata = core_wdata_in;
    // sample read data at cycle end
    if (!st_r.wr && !st_r.req_n) begin
      st_nxt.rdata = data_in;
    end
    st_nxt.mode_n = ~core_mode_in;
    // translate low in user or forced
    st_nxt.user_access_indicator_n_n = ~((core_mode_in == MBI_MODE_USER) | core_force_user_access_indicator_n_in);
    // the raw reset starts dummy fetches at once; the synced copy stretches them past release
    if (rst_in || rst_pin) begin
      st_nxt.abort = ~st_r.in_reset;
      st_nxt.in_reset = 1'b1;
      // dummy fetch, wraps naturally at top
      st_nxt.addr = st_r.addr + MBI_ADDR_STEP;
      st_nxt.wr = 1'b0;
      st_nxt.req_n = 1'b0;
      st_nxt.seq = 1'b1;
      st_nxt.user_access_indicator_n_n = 1'b1;
    end else if (st_r.in_reset) begin
      st_nxt.in_reset = 1'b0;
      st_nxt.addr = MBI_RESET_VECTOR;
      st_nxt.wr = 1'b0;
      st_nxt.req_n = 1'b0;
      st_nxt.seq = 1'b0;
    end else begin
      // next cycle presented one cycle ahead
      case (op)
        MBI_OP_SEQ: begin
          st_nxt.addr = st_r.addr + MBI_ADDR_STEP;
          st_nxt.req_n = 1'b0;
          st_nxt.seq = 1'b1;
          st_nxt.wr = core_write_in;
        end
        MBI_OP_JUMP: begin
          // idle then same address is consecutive
          st_nxt.seq = st_r.req_n & (core_jump_addr_in == st_r.addr);
          st_nxt.addr = core_jump_addr_in;
          st_nxt.req_n = 1'b0;
          st_nxt.wr = core_write_in;
        end
        MBI_OP_IDLE: begin
          st_nxt.req_n = 1'b1;
          st_nxt.seq = 1'b0;
          st_nxt.wr = 1'b0;
        end
        default: begin
          st_nxt.req_n = 1'b1;
          st_nxt.seq = 1'b0;
          st_nxt.wr = 1'b0;
        end
      endcase
    end
  end

  // reset keeps the dummy fetch sequencer running; reset, latch and address enable synchroniser stages start high so those enables act from release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= st_nxt;
      st_r.ale_s <= MBI_RST_SYNC_INIT;
      st_r.ale_a <= MBI_RST_SYNC_INIT;
      st_r.abe_s <= MBI_RST_SYNC_INIT;
      st_r.abe_a <= MBI_RST_SYNC_INIT;
      st_r.rst_a <= MBI_RST_SYNC_INIT;
      st_r.rst_b <= MBI_RST_SYNC_INIT;
      st_r.mode_n <= ~MBI_MODE_SVC;
    end else begin
      st_r <= st_nxt;
    end
  end

  // address goes through the latch stage
  assign cyc.next_addr = st_nxt.addr;
  assign cyc.latch_en = ale_q;
  mbi_addr_latch u_latch (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cyc(cyc.lat)
  );

  // outputs; the hint, request and direction lead by one cycle
  // hint one cycle ahead
  assign next_addr_consecutive_out = st_r.seq;
  assign mem_request_n_out = st_r.req_n;
  assign write_read_out = st_r.wr;
  assign user_access_indicator_n_out = st_r.user_access_indicator_n_n;
  assign mode_n_out = st_r.mode_n;
  assign addr_out = cyc.pin_addr;
  assign addr_oe_n_out = {26{~abe_q}};
  // write data held across the cycle
  assign data_out = st_r.wdata;
  assign data_oe_n_out = {32{~(st_r.wr_now & dbe_q)}};
  assign core_abort_out = st_r.abort;
  assign core_rdata_out = st_r.rdata;
  assign core_fetching_out = st_r.in_reset;

  a_reset_incr: assert property (@(posedge clk_in) disable iff (rst_in)
    rst_pin && st_r.in_reset |=> st_r.addr == $past(st_r.addr) + MBI_ADDR_STEP) else $error("dummy fetch no increment");
  a_restart_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    !rst_pin && st_r.in_reset |=> st_r.addr == MBI_RESET_VECTOR && !st_r.req_n) else $error("no restart at zero");
  a_reset_abort: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(rst_pin) && !st_r.in_reset |=> core_abort_out) else $error("no abort on reset");
  a_wrap_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    rst_pin && st_r.addr == 26'h3fffffc |=> st_r.addr == 26'h0000000) else $error("no wrap");
  a_user_access_indicator_n_user: assert property (@(posedge clk_in) disable iff (rst_in)
    !rst_pin && core_mode_in == MBI_MODE_USER |=> !user_access_indicator_n_out) else $error("translate not low");
  a_mode_inv: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> mode_n_out == ~$past(core_mode_in)) else $error("mode lines wrong");
  a_seq_incr: assert property (@(posedge clk_in) disable iff (rst_in)
    !rst_pin && !st_r.in_reset && op == MBI_OP_SEQ |=> next_addr_consecutive_out && !mem_request_n_out)
    else $error("consecutive hint missing");
  a_addr_off: assert property (@(posedge clk_in) disable iff (rst_in)
    !abe_q |-> addr_oe_n_out == 26'h3ffffff) else $error("address driven while disabled");
  a_data_read: assert property (@(posedge clk_in) disable iff (rst_in)
    !st_r.wr_now || !dbe_q |-> data_oe_n_out == 32'hffffffff) else $error("data driven outside write");
  c_reset_run: cover property (@(posedge clk_in) disable iff (rst_in) $fell(st_r.in_reset));
  c_write: cover property (@(posedge clk_in) disable iff (rst_in) data_oe_n_out == 32'h00000000);
  c_idle_same: cover property (@(posedge clk_in) disable iff (rst_in) st_r.req_n ##1 next_addr_consecutive_out);
endmodule
`default_nettype wire

// >>> rtl/mbi_pkg.sv
// shared constants and types for the processor memory bus interface
package mbi_pkg;
  localparam int MBI_ADDR_W = 26;
  localparam int MBI_DATA_W = 32;
  localparam logic [25:0] MBI_RESET_VECTOR = 26'h0000000;
  localparam logic [25:0] MBI_ADDR_STEP = 26'h0000004;
  localparam logic [1:0] MBI_MODE_USER = 2'h0;
  localparam logic [1:0] MBI_MODE_SVC = 2'h3;
  localparam logic [1:0] MBI_RST_SYNC_INIT = 2'h3;
  // cycle kinds that the core asks for
  typedef enum logic [1:0] {MBI_OP_SEQ, MBI_OP_JUMP, MBI_OP_IDLE} mbi_op_t;
  typedef enum {MBI_ST_RESET, MBI_ST_RUN} mbi_state_t;
endpackage

// >>> rtl/mbi_cyc_if.sv
// interface between the bus sequencer and its address latch stage
`timescale 1ns/1ps
`default_nettype none
interface mbi_cyc_if;
  logic [25:0] next_addr;
  logic latch_en;
  logic [25:0] pin_addr;
  modport seq (output next_addr, output latch_en, input pin_addr);
  modport lat (input next_addr, input latch_en, output pin_addr);
endinterface
`default_nettype wire

// >>> rtl/mbi_addr_latch.sv
// address latch stage: passes new address while enabled, else holds
`timescale 1ns/1ps
`default_nettype none
module mbi_addr_latch
  import mbi_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // sequencer side
  mbi_cyc_if.lat cyc
);
  typedef struct packed {
    logic [25:0] held;
  } mbi_lat_st_t;
  mbi_lat_st_t st_r, st_nxt;

  // hold register models the dynamic latch in a clocked form
  always_comb begin
    st_nxt = st_r;
    if (cyc.latch_en) begin
      st_nxt.held = cyc.next_addr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // during reset the dummy fetch addresses flow straight to the pins
      st_r.held <= cyc.next_addr;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cyc.pin_addr = st_r.held;

  a_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !cyc.latch_en |=> $stable(cyc.pin_addr)) else $error("address changed while latch closed");
endmodule
`default_nettype wire

// >>> sim/mbi_mem_model.sv
// memory system model: answers reads with an address pattern, catches writes
`timescale 1ns/1ps
`default_nettype none
module mbi_mem_model (
  // bus side
  input wire logic clk_in,
  input wire logic [25:0] addr_in,
  input wire logic [31:0] data_in,
  input wire logic [31:0] data_oe_n_in,
  // memory side
  output logic [31:0] data_out,
  output logic [31:0] last_wr_out
);
  // read data present
  // read data stands the whole cycle, so it is valid well before the cycle ends
  always_comb begin
    if (data_oe_n_in === 32'h0) data_out = data_in;
    else data_out = {6'h0, addr_in} ^ 32'h5a5a0000;
  end
  // keep the last word the processor wrote
  always_ff @(posedge clk_in) begin
    if (data_oe_n_in === 32'h0) last_wr_out <= data_in;
  end
endmodule
`default_nettype wire

// >>> sim/mbi_bus_if_tb.sv
// testbench for the processor memory bus interface
`timescale 1ns/1ps
`default_nettype none
module mbi_bus_if_tb;
  import mbi_pkg::*;
  logic clk_in = 0, rst_in = 1, wr = 0, ft = 0, ale = 1, abe = 1, dbe = 1, ab_seen = 0, abt, fet, wro, rqn, sq, trn;
  logic [1:0] op = 2'h2, mode = 2'h3, mdn;
  logic [25:0] ja = 26'h0, a, aoe;
  logic [31:0] wd = 32'h0, rd, din, dout, doe, lw;
  logic [7:0] rows [5] = '{8'h03, 8'h46, 8'h91, 8'hc4, 8'hd0};
  int num_errors = 0, n_tests = 0, i;
  mbi_bus_if mbi_bus_if_i (.clk_in(clk_in), .rst_in(rst_in), .core_op_in(op), .core_jump_addr_in(ja),
    .core_write_in(wr), .core_force_user_access_indicator_n_in(ft), .core_mode_in(mode), .core_wdata_in(wd),
    .core_abort_out(abt), .core_rdata_out(rd), .core_fetching_out(fet), .addr_latch_enable_in(ale),
    .addr_drive_enable_in(abe), .data_drive_enable_in(dbe), .addr_out(a), .addr_oe_n_out(aoe),
    .write_read_out(wro), .mem_request_n_out(rqn), .next_addr_consecutive_out(sq),
    .user_access_indicator_n_out(trn), .mode_n_out(mdn), .data_in(din), .data_out(dout), .data_oe_n_out(doe));
  mbi_mem_model mbi_mem_model_i (.clk_in(clk_in), .addr_in(a), .data_in(dout), .data_oe_n_in(doe),
    .data_out(din), .last_wr_out(lw));
  // free running clock, 25 ns period
  initial forever #12.5 clk_in = ~clk_in;
  // remember an abort pulse, it stands only one cycle
  always @(posedge clk_in) if (abt === 1'b1) ab_seen <= 1'b1;
  task cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // bounded wait for an address; running out counts as a mismatch and ends the run
  task seek(input logic [25:0] e);
    for (i = 0; i < 12 && a !== e; i++) cyc(1);
    cmp(a, e);
    if (a !== e) give_verdict;
  endtask
  // one jump cycle, then idle
  task jump(input logic [25:0] t, input logic w);
    op = MBI_OP_JUMP;
    ja = t;
    wr = w;
    cyc(1);
    op = MBI_OP_IDLE;
  endtask
  initial begin
    logic [25:0] p;
    logic seen;
    cyc(5);
    cyc(1);
    cmp(rqn, 1'b0);
    cmp(fet, 1'b1);
    rst_in = 0;
    seek(MBI_RESET_VECTOR);
    op = MBI_OP_SEQ;
    cyc(5);
    p = a;
    cyc(1);
    cmp(a - p, MBI_ADDR_STEP);
    cmp({sq, rqn}, 2'h2);
    $display("test reset and sequence done");
    // table rows: mode, force bit, translate level, inverted mode
    for (int r = 0; r < 5; r++) begin
      mode = rows[r][7:6];
      ft = rows[r][4];
      cyc(3);
      cmp(trn, rows[r][2]);
      cmp(mdn, rows[r][1:0]);
    end
    $display("test mode rows done");
    mode = MBI_MODE_SVC;
    ft = 0;
    jump(26'h100, 0);
    seek(26'h100);
    cmp(wro, 1'b0);
    seen = 0;
    for (int k = 0; k < 8; k++) begin
      seen |= (doe !== 32'hffffffff) | (rd === 32'h5a5a0100);
      cyc(1);
    end
    cmp(doe, 32'hffffffff);
    cmp(rd, 32'h5a5a0100);
    jump(26'h100, 0);
    seen = 0;
    for (int k = 0; k < 3; k++) begin
      seen |= (sq === 1'b1);
      cyc(1);
    end
    cmp(seen, 1'b1);
    $display("test read done");
    wd = 32'hc3a51e0f;
    jump(26'h200, 1);
    for (i = 0; i < 8 && doe !== 32'h0; i++) cyc(1);
    cmp(dout, wd);
    cyc(1);
    cmp(lw, wd);
    dbe = 0;
    cyc(4);
    jump(26'h300, 1);
    seen = 0;
    for (int k = 0; k < 8; k++) begin
      seen |= (doe !== 32'hffffffff);
      cyc(1);
    end
    cmp(seen, 1'b0);
    dbe = 1;
    $display("test write done");
    abe = 0;
    cyc(4);
    cmp(aoe, 26'h3ffffff);
    abe = 1;
    cyc(4);
    cmp(aoe, 26'h0);
    ale = 0;
    op = MBI_OP_SEQ;
    cyc(4);
    p = a;
    cyc(2);
    cmp(a, p);
    ale = 1;
    cyc(5);
    cmp(a !== p, 1'b1);
    $display("test drivers and latch done");
    jump(26'h3fffff8, 0);
    seek(26'h3fffff8);
    ab_seen = 0;
    rst_in = 1;
    seek(26'h3fffffc);
    seek(26'h0);
    cmp(ab_seen, 1'b1);
    rst_in = 0;
    cyc(6);
    $display("test wrap in reset done");
    give_verdict;
  end
endmodule
`default_nettype wire
